// ---- dv/sfsl_chk.sv ----
`timescale 1ns/1ps
module sfsl_chk import sfsl_pkg::*; #(
  parameter int BLANK_CYC = sfsl_pkg::BLANK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic ctl_m_oe,
  input wire logic dat_m_oe,
  input wire logic dat_s_o,
  input wire logic dat_s_oe,
  input wire logic ctl_lvl,
  input wire logic dat_lvl
);
  // Master gets some slack to react to a slave fault
  localparam int FD_MAX = RES_CYC + 40;
  int lo_cnt;
  int so_run;
  int fd_cnt;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lo_cnt <= 0;
    end else begin
      lo_cnt <= ctl_lvl ? 0 : lo_cnt + 1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      so_run <= 0;
    end else begin
      so_run <= dat_s_oe ? so_run + 1 : 0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fd_cnt <= 0;
    end else begin
      fd_cnt <= (ctl_lvl && !dat_lvl && !dat_m_oe) ? fd_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  AST_SLV_LOW_ONLY: assert property (dat_s_oe |-> !dat_s_o)
    else $error("slave drives data high");
  AST_CTL_OWNED: assert property (ctl_m_oe)
    else $error("control line not driven by master");
  AST_NO_CONTEND: assert property (dat_m_oe |-> !dat_s_oe)
    else $error("slave drives data during transfer");
  AST_PRE_CTL: assert property ($rose(dat_m_oe) |-> ctl_lvl [*8])
    else $error("control low during preamble");
  AST_BIT_HALF: assert property ($rose(ctl_lvl) && dat_m_oe |-> lo_cnt == LINK_HALF_CYC)
    else $error("bit clock low phase wrong");
  AST_RES_LEN: assert property ($fell(dat_s_oe) && ctl_lvl |-> so_run == RES_CYC)
    else $error("mismatch report length wrong");
  AST_BLANK_LEN: assert property ($fell(dat_s_oe) && !ctl_lvl |-> so_run >= BLANK_CYC)
    else $error("data released before blanking ended");
  AST_FLT_CTL_DROP: assert property (fd_cnt <= FD_MAX)
    else $error("control not dropped on slave fault");
endmodule : sfsl_chk

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  import sfsl_pkg::*;
  localparam int BLK = 200;
  localparam int LIMIT = 80000;
  // Bench-made link clock: 200 ns period
  localparam int BHALF = 4;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_enable = 1'b0;
  logic i_master_fault = 1'b0;
  logic [CFG_W-1:0] i_cfg_data = 8'h00;
  logic i_cfg_valid = 1'b0;
  logic [FLT_W-1:0] flt0 = 6'h00;
  logic [FLT_W-1:0] flt1 = 6'h00;
  logic o_cfg_ready, o_cmd_blank, o_running, o_xfer_fail, o_shutdown;
  logic [CFG_W-1:0] ocp0, ot0, ad0, ocp1, ot1, ad1;
  logic sb0, pc0, se0, mm0, mm1;
  logic [31:0] seed = 32'h0000_06f2;
  logic [31:0] f;
  logic [CFG_W-1:0] mq [$];
  int n_errors = 0;
  int n_tests = 0;
  int n_push;
  int npulse = 0;
  int hi = 0;
  int cyc = 0;

  sfsl_link_if lnk();
  sfsl_link_if lnk2();

  sfsl_master #(.BLANK_CYC(BLK), .TON_CYC(50)) i_sfsl_master (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .link(lnk), .i_enable(i_enable),
    .i_master_fault(i_master_fault), .i_cfg_data(i_cfg_data), .i_cfg_valid(i_cfg_valid),
    .o_cfg_ready(o_cfg_ready), .o_cmd_blank(o_cmd_blank), .o_running(o_running),
    .o_xfer_fail(o_xfer_fail), .o_shutdown(o_shutdown));
  sfsl_slave #(.BLANK_CYC(BLK)) i_sfsl_slave (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .link(lnk), .i_fault(flt0), .o_ocp_cfg(ocp0),
    .o_ot_cfg(ot0), .o_addr_cfg(ad0), .o_standby(sb0), .o_precharge(pc0), .o_ss_en(se0),
    .o_mismatch(mm0));
  // Second slave faces a bench driver that can send corrupt frames
  sfsl_slave #(.BLANK_CYC(BLK)) i_sfsl_slave_2 (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .link(lnk2), .i_fault(flt1), .o_ocp_cfg(ocp1),
    .o_ot_cfg(ot1), .o_addr_cfg(ad1), .o_standby(), .o_precharge(), .o_ss_en(),
    .o_mismatch(mm1));
  sfsl_chk #(.BLANK_CYC(BLK)) i_sfsl_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .ctl_m_oe(lnk.ctl_m_oe), .dat_m_oe(lnk.dat_m_oe),
    .dat_s_o(lnk.dat_s_o), .dat_s_oe(lnk.dat_s_oe), .ctl_lvl(lnk.ctl_lvl),
    .dat_lvl(lnk.dat_lvl));

  always #12.5 i_clk = ~i_clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  task automatic chk8(input logic [CFG_W-1:0] act, input logic [CFG_W-1:0] exp);
    n_tests++;
    if (act !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : chk8

  task automatic chk1(input logic act, input logic exp);
    n_tests++;
    if (act !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : chk1

  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic push(input int n, input int lim);
    n_push = 0;
    for (int k = 0; k < lim && n_push < n; k++) begin
      seed = xs(seed);
      i_cfg_data <= seed[7:0];
      i_cfg_valid <= 1'b1;
      @(posedge i_clk);
      if (o_cfg_ready === 1'b1) begin
        mq.push_back(i_cfg_data);
        n_push++;
      end
    end
    i_cfg_valid <= 1'b0;
  endtask : push

  // Bench plays master on the second link; first frame has a bad checksum on purpose
  task automatic send_frame(input logic [31:0] fr);
    lnk2.ctl_m_o <= 1'b1;
    for (int k = 0; k < 2 * PRE_PULSES; k++) begin
      lnk2.dat_m_oe <= 1'b1;
      lnk2.dat_m_o <= k[0];
      repeat (PRE_HALF_CYC) @(posedge i_clk);
    end
    for (int k = FRAME_BITS - 1; k >= 0; k--) begin
      lnk2.ctl_m_o <= 1'b0;
      lnk2.dat_m_o <= fr[k];
      repeat (BHALF) @(posedge i_clk);
      lnk2.ctl_m_o <= 1'b1;
      repeat (BHALF) @(posedge i_clk);
    end
    lnk2.dat_m_oe <= 1'b0;
    repeat (RES_SAMPLE_CYC) @(posedge i_clk);
  endtask : send_frame

  task automatic run_copy();
    logic [CFG_W-1:0] e [3];
    npulse = 0;
    for (int k = 0; k < 12000 && !(o_running === 1'b1 && pc0 === 1'b0); k++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 3; k++) e[k] = mq.pop_front();
    chk1(o_running, 1'b1);
    chk1(se0, 1'b1);
    chk8(8'(npulse), 8'(SS_PULSES));
    chk8(ocp0, e[0]);
    chk8(ot0, e[1]);
    chk8(ad0, e[2]);
    chk1(mm0, 1'b0);
    chk1(o_xfer_fail, 1'b0);
    chk1(o_shutdown, 1'b0);
    chk1(lnk.dat_lvl, 1'b1);
    $display("test copy done");
  endtask : run_copy

  // Width of each control pulse seen while the slave precharges
  always @(posedge i_clk) begin
    if (lnk.ctl_lvl === 1'b1) begin
      hi <= hi + 1;
    end else begin
      if (hi != 0 && pc0 === 1'b1) begin
        npulse++;
        chk1(hi == PULSE_CYC, 1'b1);
      end
      hi <= 0;
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    lnk2.ctl_m_oe = 1'b1;
    lnk2.ctl_m_o = 1'b0;
    lnk2.dat_m_oe = 1'b0;
    lnk2.dat_m_o = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk1(lnk.dat_lvl, 1'b0);
    chk1(sb0, 1'b0);
    chk8(ocp0, DEF_OCP);
    chk8(ot1, DEF_OT);
    chk8(ad1, DEF_ADDR);
    repeat (BLK + 20) @(posedge i_clk);
    chk1(lnk.dat_lvl, 1'b1);
    chk1(sb0, 1'b1);
    $display("test reset done");
    for (int g = 0; g < 2; g++) begin
      seed = xs(seed);
      f = {seed[23:0], seed[23:16] ^ seed[15:8] ^ seed[7:0] ^ CHK_SEED ^ {7'h00, g == 0}};
      send_frame(f);
      chk1(lnk2.dat_lvl, g == 1);
      repeat (RES_CYC - RES_SAMPLE_CYC) @(posedge i_clk);
      chk1(mm1, g == 0);
      chk8(ocp1, g == 1 ? f[31:24] : DEF_OCP);
      chk8(ot1, g == 1 ? f[23:16] : DEF_OT);
      chk8(ad1, g == 1 ? f[15:8] : DEF_ADDR);
    end
    lnk2.ctl_m_o <= 1'b0;
    $display("test frames done");
    push(FIFO_DEPTH + 4, 40);
    chk8(8'(n_push), 8'(FIFO_DEPTH));
    $display("test fill done");
    i_enable <= 1'b1;
    repeat (BLK - 10) @(posedge i_clk);
    chk1(o_cmd_blank, 1'b1);
    repeat (20) @(posedge i_clk);
    chk1(o_cmd_blank, 1'b0);
    run_copy();
    for (int b = 0; b < FLT_W; b++) begin
      flt0 <= 6'h01 << b;
      repeat (24) @(posedge i_clk);
      flt0 <= 6'h00;
      chk1(lnk.dat_lvl, 1'b0);
      chk1(lnk.ctl_lvl, 1'b0);
      chk1(se0, 1'b0);
      chk8(ocp0, DEF_OCP);
      if (mq.size() < 3) begin
        push(3 - mq.size(), 40);
      end
      run_copy();
    end
    i_master_fault <= 1'b1;
    repeat (24) @(posedge i_clk);
    i_master_fault <= 1'b0;
    chk1(lnk.ctl_lvl, 1'b0);
    chk1(o_running, 1'b0);
    chk1(se0, 1'b0);
    chk8(ocp0, DEF_OCP);
    $display("test master fault done");
    give_verdict();
  end
endmodule : tb

// ---- inc/sfsl_link_if.sv ----
`timescale 1ns/1ps
interface sfsl_link_if;
  logic ctl_m_o;
  logic ctl_m_oe;
  logic dat_m_o;
  logic dat_m_oe;
  logic dat_s_o;
  logic dat_s_oe;
  logic ctl_lvl;
  logic dat_lvl;
  // Open-drain lines with pull-up: any driver pulling low wins
  assign ctl_lvl = ~(ctl_m_oe & ~ctl_m_o);
  assign dat_lvl = ~((dat_m_oe & ~dat_m_o) | (dat_s_oe & ~dat_s_o));
  modport master (output ctl_m_o, output ctl_m_oe, output dat_m_o, output dat_m_oe,
                  input ctl_lvl, input dat_lvl);
  modport slave (output dat_s_o, output dat_s_oe, input ctl_lvl, input dat_lvl);
endinterface : sfsl_link_if

// ---- inc/sfsl_pkg.sv ----
package sfsl_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int LINK_HZ = 400_000;
  localparam int LINK_HALF_CYC = CLK_HZ / (2 * LINK_HZ);
  localparam int BLANK_US = 2000;
  localparam int BLANK_CYC = BLANK_US * CYC_PER_US;
  localparam int PULSE_US = 8;
  localparam int PULSE_CYC = PULSE_US * CYC_PER_US;
  localparam int TON_US = 100;
  localparam int TON_CYC = TON_US * CYC_PER_US;
  localparam int RES_CYC = 4 * LINK_HALF_CYC;
  localparam int RES_SAMPLE_CYC = 2 * LINK_HALF_CYC;
  localparam int PRE_PULSES = 4;
  localparam int PRE_HALF_CYC = 4;
  localparam int PRE_MIN_EDGES = 2;
  localparam int SS_PULSES = 3;
  localparam int XFER_TRIES = 3;
  localparam int MAX_SLAVES = 6;
  localparam int CFG_W = 8;
  localparam int CFG_WORDS = 3;
  localparam int FRAME_BITS = CFG_W * (CFG_WORDS + 1);
  localparam int FIFO_DEPTH = 16;
  localparam logic [CFG_W-1:0] DEF_OCP = 8'h0a;
  localparam logic [CFG_W-1:0] DEF_OT = 8'h27;
  localparam logic [CFG_W-1:0] DEF_ADDR = 8'h00;
  localparam logic [CFG_W-1:0] CHK_SEED = 8'h5a;
  localparam int FLT_W = 6;
  localparam int FLT_SS_CL = 0;
  localparam int FLT_UVLO = 1;
  localparam int FLT_FET = 2;
  localparam int FLT_OCP = 3;
  localparam int FLT_SCP = 4;
  localparam int FLT_OT = 5;

  function automatic logic [CFG_W-1:0] sfsl_chk(input logic [FRAME_BITS-1:0] f);
    sfsl_chk = f[4*CFG_W-1:3*CFG_W] ^ f[3*CFG_W-1:2*CFG_W] ^ f[2*CFG_W-1:CFG_W] ^ CHK_SEED;
  endfunction : sfsl_chk
endpackage : sfsl_pkg

// ---- src/sfsl_fifo.sv ----
`timescale 1ns/1ps
module sfsl_fifo #(
  parameter int W = sfsl_pkg::CFG_W,
  parameter int DEPTH = sfsl_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  import sfsl_pkg::*;
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sfsl_fifo depth must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign push = i_valid & o_ready;
  assign pop = i_ready & o_valid;
  assign o_data = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      // Flags registered from the next count, so they stay honest
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
      o_ready <= (count + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
      o_valid <= (count + (AW+1)'(push) - (AW+1)'(pop)) != '0;
    end
  end
endmodule : sfsl_fifo

// ---- src/sfsl_master.sv ----
`timescale 1ns/1ps
module sfsl_master #(
  parameter int BLANK_CYC = sfsl_pkg::BLANK_CYC,
  parameter int TON_CYC = sfsl_pkg::TON_CYC,
  parameter bit PROCEED_DEFAULT = 1'b1,
  parameter int N_SLAVES = 1,
  parameter int DEPTH = sfsl_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  sfsl_link_if.master link,
  input wire logic i_enable,
  input wire logic i_master_fault,
  input wire logic [sfsl_pkg::CFG_W-1:0] i_cfg_data,
  input wire logic i_cfg_valid,
  output logic o_cfg_ready,
  output logic o_cmd_blank,
  output logic o_running,
  output logic o_xfer_fail,
  output logic o_shutdown
);
  import sfsl_pkg::*;
  if (N_SLAVES < 1 || N_SLAVES > MAX_SLAVES) begin : g_chk_n
    $error("sfsl_master supports one to six slaves");
  end
  if (BLANK_CYC < 1 || TON_CYC < 1) begin : g_chk_t
    $error("sfsl_master timing counts must be positive");
  end
  localparam int CW = $clog2(TON_CYC + 2 * RES_CYC + 1) + 1;
  localparam int BW = $clog2(BLANK_CYC + 1);
  typedef enum logic [8:0] {
    M_IDLE = 9'h001, M_LOADF = 9'h002, M_PRE = 9'h004, M_BITS = 9'h008, M_RES = 9'h010,
    M_TON = 9'h020, M_PULSE = 9'h040, M_RUN = 9'h080, M_DEAD = 9'h100
  } sfsl_mstate_t;
  sfsl_mstate_t state, next_state;
  logic [1:0] dat_sync;
  logic [CW-1:0] cnt;
  logic [5:0] bit_cnt;
  logic [1:0] word_cnt;
  logic [1:0] tries;
  logic [2:0] toggles;
  logic [CFG_WORDS*CFG_W-1:0] tx_cfg;
  logic [FRAME_BITS-1:0] frame;
  logic res_low;
  logic en_q;
  logic [BW-1:0] blank_cnt;
  logic f_valid;
  logic f_pop;
  logic [CFG_W-1:0] f_data;
  logic dat_hi;
  logic slave_flt;
  logic stop;

  assign dat_hi = dat_sync[1];
  assign slave_flt = ~dat_sync[1];
  assign stop = ~i_enable | i_master_fault;
  assign frame = {tx_cfg, sfsl_chk({tx_cfg, {CFG_W{1'b0}}})};
  assign f_pop = (state == M_LOADF) & f_valid;

  sfsl_fifo #(.W(CFG_W), .DEPTH(DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_valid(i_cfg_valid),
    .o_ready(o_cfg_ready),
    .i_data(i_cfg_data),
    .o_valid(f_valid),
    .i_ready(f_pop),
    .o_data(f_data)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // Slave holds data low in reset; a high start would fake readiness
      dat_sync <= 2'b00;
    end else begin
      dat_sync <= {dat_sync[0], link.dat_lvl};
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      M_IDLE: if (i_enable && !i_master_fault && dat_hi) next_state = M_LOADF;
      M_LOADF: if (stop) next_state = M_IDLE;
        else if (f_pop && word_cnt == 2'(CFG_WORDS - 1)) next_state = M_PRE;
      M_PRE: if (cnt == CW'(2 * PRE_PULSES * PRE_HALF_CYC - 1)) next_state = M_BITS;
      M_BITS: if (cnt == CW'(2 * LINK_HALF_CYC - 1) && bit_cnt == 6'(FRAME_BITS - 1)) begin
        next_state = M_RES;
      end
      M_RES: if (cnt == CW'(RES_CYC - 1)) begin
        if (!res_low) next_state = M_TON;
        else if (tries != 2'(XFER_TRIES - 1)) next_state = M_PRE;
        else next_state = PROCEED_DEFAULT ? M_TON : M_DEAD;
      end
      M_TON: if (stop || slave_flt) next_state = M_IDLE;
        else if (cnt == CW'(TON_CYC - 1)) next_state = M_PULSE;
      M_PULSE: if (stop || slave_flt) next_state = M_IDLE;
        else if (cnt == CW'(PULSE_CYC - 1) && toggles == 3'(2 * SS_PULSES - 1)) begin
          next_state = M_RUN;
        end
      M_RUN: if (stop || slave_flt) next_state = M_IDLE;
      M_DEAD: if (!i_enable) next_state = M_IDLE;
      default: next_state = M_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= M_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= '0;
      bit_cnt <= '0;
      toggles <= '0;
    end else if (state != next_state) begin
      cnt <= '0;
      bit_cnt <= '0;
      toggles <= '0;
    end else if (state == M_BITS && cnt == CW'(2 * LINK_HALF_CYC - 1)) begin
      cnt <= '0;
      bit_cnt <= bit_cnt + 1'b1;
    end else if (state == M_PULSE && cnt == CW'(PULSE_CYC - 1)) begin
      cnt <= '0;
      toggles <= toggles + 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_cfg <= {DEF_OCP, DEF_OT, DEF_ADDR};
      word_cnt <= '0;
      tries <= '0;
      res_low <= 1'b0;
    end else begin
      if (f_pop) begin
        tx_cfg <= {tx_cfg[(CFG_WORDS-1)*CFG_W-1:0], f_data};
        word_cnt <= (word_cnt == 2'(CFG_WORDS - 1)) ? 2'd0 : word_cnt + 1'b1;
      end else if (state == M_IDLE) begin
        word_cnt <= '0;
      end
      if (state == M_IDLE) begin
        tries <= '0;
      end else if (state == M_RES && next_state == M_PRE) begin
        tries <= tries + 1'b1;
      end
      if (state != M_RES) begin
        res_low <= 1'b0;
      end else if (cnt == CW'(RES_SAMPLE_CYC) && slave_flt) begin
        res_low <= 1'b1;
      end
    end
  end

  // Line drivers are registered from the next state to stay glitch free
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      link.ctl_m_o <= 1'b0;
      link.ctl_m_oe <= 1'b1;
      link.dat_m_o <= 1'b1;
      link.dat_m_oe <= 1'b0;
    end else begin
      link.ctl_m_oe <= 1'b1;
      case (next_state)
        M_LOADF, M_PRE, M_RES, M_RUN: link.ctl_m_o <= 1'b1;
        M_BITS: link.ctl_m_o <= (state == M_BITS) && (cnt >= CW'(LINK_HALF_CYC - 1))
                                && (cnt != CW'(2 * LINK_HALF_CYC - 1));
        // Pulses open high so the slave sees three falls before the run level
        M_PULSE: link.ctl_m_o <= (state != M_PULSE) ||
                                 ((cnt == CW'(PULSE_CYC - 1)) ^ link.ctl_m_o);
        default: link.ctl_m_o <= 1'b0;
      endcase
      link.dat_m_oe <= (next_state == M_PRE) || (next_state == M_BITS);
      if (next_state == M_PRE) begin
        link.dat_m_o <= (state == M_PRE) ? ((cnt + 1'b1) / CW'(PRE_HALF_CYC)) % 2 == 1 : 1'b0;
      end else if (next_state == M_BITS) begin
        link.dat_m_o <= frame[FRAME_BITS - 1 - ((state == M_BITS &&
                        cnt == CW'(2 * LINK_HALF_CYC - 1)) ? bit_cnt + 1'b1 : bit_cnt)];
      end else begin
        link.dat_m_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_q <= 1'b0;
      blank_cnt <= '0;
      o_cmd_blank <= 1'b0;
      o_running <= 1'b0;
      o_xfer_fail <= 1'b0;
      o_shutdown <= 1'b0;
    end else begin
      en_q <= i_enable;
      if (i_enable && !en_q) begin
        blank_cnt <= BW'(BLANK_CYC - 1);
        o_cmd_blank <= 1'b1;
      end else if (blank_cnt != '0) begin
        blank_cnt <= blank_cnt - 1'b1;
      end else begin
        o_cmd_blank <= 1'b0;
      end
      o_running <= next_state == M_RUN;
      o_shutdown <= next_state == M_DEAD;
      if (state == M_RES && next_state != M_PRE && cnt == CW'(RES_CYC - 1)) begin
        o_xfer_fail <= res_low;
      end
    end
  end
endmodule : sfsl_master

// ---- src/sfsl_slave.sv ----
`timescale 1ns/1ps
// Summary of operation
// - On supply good load defaults, then standby.
// - Transfer: master clocks control line, drives data.
// - After transfer, pull data low on mismatch.
// - Master tries a failed transfer three times.
// - After three failures: defaults or shutdown, fixed.
// - Soft-start begins on control line high level.
// - Three 8us control pulses precharge and synchronise.
// - Outside transfer control line is input only.
// - Outside transfer data line only signals faults.
// - Master blanks host commands 2 ms after enable.
// - After 2 ms blanking, release data when fault-free.
// - Master raises control line; transfer then starts.
// - Fast data burst with control high starts transfer.
// - After transfer both lines revert to fault use.
// - Data low forces control low; all outputs off.
// - At most six slaves per master.
// - Transfer carries overcurrent, overtemperature, address settings.
// - One broadcast frame reaches all slaves together.
// - Copy repeats after every fault and power cycle.
// - Settings fixed before enabling, never changed midway.
// - Transfer clock 400 kHz, about 120 us total; the code sends 32 bits, about 86 us with preamble and result window.
// - Pull data low on any listed fault.
module sfsl_slave #(
  parameter int BLANK_CYC = sfsl_pkg::BLANK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  sfsl_link_if.slave link,
  input wire logic [sfsl_pkg::FLT_W-1:0] i_fault,
  output logic [sfsl_pkg::CFG_W-1:0] o_ocp_cfg,
  output logic [sfsl_pkg::CFG_W-1:0] o_ot_cfg,
  output logic [sfsl_pkg::CFG_W-1:0] o_addr_cfg,
  output logic o_standby,
  output logic o_precharge,
  output logic o_ss_en,
  output logic o_mismatch
);
  import sfsl_pkg::*;
  if (BLANK_CYC < 1) begin : g_chk
    $error("sfsl_slave blanking count must be positive");
  end
  localparam int CW = $clog2(BLANK_CYC + RES_CYC + 2 * PULSE_CYC + 1);
  typedef enum logic [9:0] {
    S_LOAD = 10'h001, S_BLANK = 10'h002, S_READY = 10'h004, S_SYNC = 10'h008,
    S_ARM = 10'h010, S_BITS = 10'h020, S_CHECK = 10'h040, S_WAIT_SS = 10'h080,
    S_SSTART = 10'h100, S_RUN = 10'h200
  } sfsl_sstate_t;
  sfsl_sstate_t state, next_state;
  logic [1:0] ctl_sync;
  logic [1:0] dat_sync;
  logic ctl_q;
  logic dat_q;
  logic ctl;
  logic ctl_rise;
  logic ctl_fall;
  logic dat_fall;
  logic fault_any;
  logic [CW-1:0] cnt;
  logic [2:0] pre_cnt;
  logic [5:0] bit_cnt;
  logic [1:0] pulse_cnt;
  logic [FRAME_BITS-1:0] rx;
  logic [FRAME_BITS-1:0] next_rx;
  logic last_bit;
  logic next_mismatch;

  // Only the second stage feeds any edge detector
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_sync <= 2'b00;
      dat_sync <= 2'b00;
      ctl_q <= 1'b0;
      dat_q <= 1'b0;
    end else begin
      ctl_sync <= {ctl_sync[0], link.ctl_lvl};
      dat_sync <= {dat_sync[0], link.dat_lvl};
      ctl_q <= ctl_sync[1];
      dat_q <= dat_sync[1];
    end
  end

  assign ctl = ctl_sync[1];
  assign ctl_rise = ctl_sync[1] & ~ctl_q;
  assign ctl_fall = ~ctl_sync[1] & ctl_q;
  assign dat_fall = ~dat_sync[1] & dat_q;
  assign fault_any = |i_fault;
  assign next_rx = {rx[FRAME_BITS-2:0], dat_sync[1]};
  assign last_bit = (state == S_BITS) && ctl_rise && (bit_cnt == 6'(FRAME_BITS - 1));
  assign next_mismatch = sfsl_chk(next_rx) != next_rx[CFG_W-1:0];

  always_comb begin
    next_state = state;
    case (state)
      S_LOAD: next_state = S_BLANK;
      S_BLANK: if (cnt == CW'(BLANK_CYC - 1)) next_state = S_READY;
      S_READY: if (ctl && !fault_any) next_state = S_SYNC;
      S_SYNC: if (pre_cnt >= 3'(PRE_MIN_EDGES)) next_state = S_ARM;
        else if (!ctl) next_state = S_WAIT_SS;
      S_ARM: if (ctl_fall) next_state = S_BITS;
      S_BITS: if (last_bit) next_state = S_CHECK;
      S_CHECK: if (cnt == CW'(RES_CYC - 1)) next_state = S_SYNC;
      S_WAIT_SS: if (fault_any) next_state = S_LOAD;
        else if (ctl_rise) next_state = S_SSTART;
      S_SSTART: if (fault_any) next_state = S_LOAD;
        else if (ctl_rise && pulse_cnt == 2'(SS_PULSES)) next_state = S_RUN;
        else if (!ctl && cnt == CW'(2 * PULSE_CYC)) next_state = S_LOAD;
      S_RUN: if (fault_any || !ctl) next_state = S_LOAD;
      default: next_state = S_LOAD;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= S_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // A low on the control line longer than two pulse widths ends soft-start
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= '0;
    end else if (state != next_state || (state == S_SSTART && ctl)) begin
      cnt <= '0;
    end else if (cnt != '1) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt <= '0;
    end else if (state != S_SYNC) begin
      pre_cnt <= '0;
    end else if (dat_fall && ctl && pre_cnt != '1) begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt <= '0;
      rx <= '0;
    end else if (state != S_BITS) begin
      bit_cnt <= '0;
    end else if (ctl_rise) begin
      rx <= next_rx;
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pulse_cnt <= '0;
    end else if (state != S_SSTART) begin
      pulse_cnt <= '0;
    end else if (ctl_fall && pulse_cnt != 2'(SS_PULSES)) begin
      pulse_cnt <= pulse_cnt + 1'b1;
    end
  end

  // A failed frame leaves the last settings in force; only S_LOAD restores defaults
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ocp_cfg <= DEF_OCP;
      o_ot_cfg <= DEF_OT;
      o_addr_cfg <= DEF_ADDR;
      o_mismatch <= 1'b0;
    end else if (state == S_LOAD) begin
      o_ocp_cfg <= DEF_OCP;
      o_ot_cfg <= DEF_OT;
      o_addr_cfg <= DEF_ADDR;
      o_mismatch <= 1'b0;
    end else if (last_bit) begin
      o_mismatch <= next_mismatch;
      if (!next_mismatch) begin
        o_ocp_cfg <= next_rx[4*CFG_W-1:3*CFG_W];
        o_ot_cfg <= next_rx[3*CFG_W-1:2*CFG_W];
        o_addr_cfg <= next_rx[2*CFG_W-1:CFG_W];
      end
    end else if (state == S_SYNC && next_state == S_ARM) begin
      o_mismatch <= 1'b0;
    end
  end

  // The data line is only ever pulled low; the pull-up gives the high
  assign link.dat_s_o = 1'b0;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      link.dat_s_oe <= 1'b1;
      o_standby <= 1'b0;
      o_precharge <= 1'b0;
      o_ss_en <= 1'b0;
    end else begin
      case (next_state)
        S_LOAD, S_BLANK: link.dat_s_oe <= 1'b1;
        S_READY, S_WAIT_SS, S_SSTART, S_RUN: link.dat_s_oe <= fault_any;
        S_CHECK: link.dat_s_oe <= (state == S_BITS) ? next_mismatch : o_mismatch;
        default: link.dat_s_oe <= 1'b0;
      endcase
      o_standby <= next_state == S_READY;
      o_precharge <= next_state == S_SSTART;
      o_ss_en <= (next_state == S_SSTART) || (next_state == S_RUN);
    end
  end
endmodule : sfsl_slave
